// *** eps_core.v ***
// Purpose: Byte-order and privilege state, register files and memory operand path.
// Assumes: Execution units compute results; an outside unit vectors exceptions.
// Notes:   One instruction at a time; single loads and stores use one 64-bit beat, word sequences one beat per register.
// Contract
// [RQ1] Big-endian by default, little-endian optional.
// [RQ2] Order bits: zero big-endian, one little-endian.
// [RQ3] Exception entry copies exception order bit.
// [RQ4] Without little-endian support, order bits reserved.
// [RQ5] Byte number equals its address.
// [RQ6] Operand addressed by its lowest byte.
// [RQ7] Byte, half, word, double and word sequences.
// [RQ8] Aligned only at multiple of length.
// [RQ9] Only loads and stores touch memory.
// [RQ10] Thirty-two general and float registers, three-register format.
// [RQ11] Every instruction is one 32-bit word.
// [RQ12] Both levels reach user-level registers.
// [RQ13] Time base readable by user, supervisor writes.
// [RQ14] State-control instructions only in supervisor mode.
// [RQ15] System call enters, return leaves supervisor.
// [RQ16] Double arithmetic gives double results.
// [RQ17] Single results rounded to single precision.
// [RQ18] Unsupported segment moves raise program exception.
// [RQ19] User privileged attempt faults, changes nothing.
`timescale 1ns/1ps
`default_nettype none
`include "eps_defs.vh"
module eps_core
#(
   parameter LE_SUPPORTED     = 1,
   parameter BRIDGE_SUPPORTED = 0
)
(
   // Clock and reset.
   input  wire        clk,
   input  wire        rst_n,
   // Instruction stream.
   input  wire        instr_valid,
   input  wire [31:0] instr_word,
   output wire        instr_ready,
   output reg         instr_done_ff,
   // Exception entry request.
   input  wire        exc_take,
   // Operand issue to execution units.
   output reg         ex_issue_ff,
   output reg         ex_float_ff,
   output reg         ex_single_ff,
   output reg  [4:0]  ex_target_ff,
   output reg  [63:0] ex_opa_ff,
   output reg  [63:0] ex_opb_ff,
   // Result write-back.
   input  wire        res_valid,
   input  wire        res_float,
   input  wire        res_single,
   input  wire [4:0]  res_idx,
   input  wire [63:0] res_data,
   // Memory interface.
   output wire        mem_req,
   output reg         mem_we_ff,
   output wire [63:0] mem_addr,
   output wire [7:0]  mem_be,
   output reg  [63:0] mem_wdata_ff,
   input  wire        mem_ack,
   input  wire [63:0] mem_rdata,
   // Status.
   output wire [63:0] machine_state_reg,
   output wire        user_mode,
   output reg         exc_priv_ff,
   output reg         exc_prog_ff,
   output reg         exc_align_ff,
   output reg         seg_op_ff
);

   localparam S_IDLE = 1'b0;
   localparam S_MEM  = 1'b1;

   reg  [63:0] general_reg [0:31];
   reg  [63:0] float_reg   [0:31];

   reg         state_ff;
   reg         nxt_state;
   reg         pr_ff;
   reg         le_ff;
   reg         ile_ff;
   reg         save_pr_ff;
   reg         save_le_ff;
   reg  [63:0] impl_specific_reg_ff;
   reg  [63:0] ea_ff;
   reg  [1:0]  size_ff;
   reg         flt_ff;
   reg         mult_ff;
   reg  [4:0]  tgt_ff;

   // Byte swap across all eight lanes.
   function [63:0] bswap;
      input [63:0] v;
      integer i;
      begin
         bswap = 64'h0000_0000_0000_0000;
         for (i = 0; i < 8; i = i + 1)
            bswap[8*i +: 8] = v[56-8*i +: 8];
      end
   endfunction

   // Lane shift that moves the last operand byte to the bottom.
   function [5:0] tail_sh;
      input [1:0] sz;
      begin
         case (sz)
            `EPS_SZ_BYTE: tail_sh = 6'd56;
            `EPS_SZ_HALF: tail_sh = 6'd48;
            `EPS_SZ_WORD: tail_sh = 6'd32;
            default:      tail_sh = 6'd0;
         endcase
      end
   endfunction

   // Mask of the low operand bytes.
   function [63:0] low_mask;
      input [1:0] sz;
      begin
         case (sz)
            `EPS_SZ_BYTE: low_mask = 64'h0000_0000_0000_00FF;
            `EPS_SZ_HALF: low_mask = 64'h0000_0000_0000_FFFF;
            `EPS_SZ_WORD: low_mask = 64'h0000_0000_FFFF_FFFF;
            default:      low_mask = 64'hFFFF_FFFF_FFFF_FFFF;
         endcase
      end
   endfunction

   // Pull an operand out of the lanes, zero-extended.
   function [63:0] ld_extract;
      input [63:0] lanes;
      input [2:0]  off;
      input [1:0]  sz;
      input        le;
      reg   [63:0] top;
      begin
         top = lanes << {off, 3'b000};
         // Lowest address is most significant unless little-endian. [RQ2]
         if (le)
            ld_extract = bswap(top) & low_mask(sz);
         else
            ld_extract = top >> tail_sh(sz);
      end
   endfunction

   // Place an operand into the lanes of its address.
   function [63:0] st_place;
      input [63:0] val;
      input [2:0]  off;
      input [1:0]  sz;
      input        le;
      begin
         if (le)
            st_place = bswap(val) >> {off, 3'b000}; // [RQ2]
         else
            st_place = (val << tail_sh(sz)) >> {off, 3'b000};
      end
   endfunction

   // Round a double to a value that single precision can hold.
   function [63:0] rnd_single;
      input [63:0] d;
      reg          inc;
      reg   [34:0] hi;
      begin
         inc = d[28] & (d[29] | (|d[27:0]));
         hi  = d[63:29] + {34'h0_0000_0000, inc};
         rnd_single = {hi, 29'h0000_0000};
      end
   endfunction

   // Decode of the single fixed-width instruction word. [RQ11]
   wire [5:0]  op   = instr_word[`EPS_F_OP];
   wire [4:0]  rt   = instr_word[`EPS_F_RT];
   wire [4:0]  ra   = instr_word[`EPS_F_RA];
   wire [4:0]  rb   = instr_word[`EPS_F_RB];
   wire [3:0]  xo   = instr_word[`EPS_F_XO];
   wire        sel  = instr_word[`EPS_B_SEL];

   wire is_alu  = (op == `EPS_OP_ALU);
   wire is_falu = (op == `EPS_OP_FALU);
   wire is_flt  = (op == `EPS_OP_LDF) | (op == `EPS_OP_STF);
   wire is_mult = (op == `EPS_OP_LMW) | (op == `EPS_OP_STMW);
   wire is_ld   = (op == `EPS_OP_LD) | (op == `EPS_OP_LDF) | (op == `EPS_OP_LMW);
   wire is_st   = (op == `EPS_OP_ST) | (op == `EPS_OP_STF) | (op == `EPS_OP_STMW);
   wire is_sys  = (op == `EPS_OP_SYS);

   wire x_sc    = is_sys & (xo == `EPS_XO_SC);
   wire x_rfi   = is_sys & (xo == `EPS_XO_RFI);
   wire x_mtmsr = is_sys & (xo == `EPS_XO_MTMSR);
   wire x_mfmsr = is_sys & (xo == `EPS_XO_MFMSR);
   wire x_mtspr = is_sys & (xo == `EPS_XO_MTSPR);
   wire x_mfspr = is_sys & (xo == `EPS_XO_MFSPR);
   wire x_seg   = is_sys & ((xo == `EPS_XO_MTSEG) | (xo == `EPS_XO_MFSEG));

   wire sp_tbl  = (rb == `EPS_SPR_TBL);
   wire sp_tbu  = (rb == `EPS_SPR_TBU);
   wire sp_impl = (rb == `EPS_SPR_IMPL);
   wire sp_known = sp_tbl | sp_tbu | sp_impl;

   wire known = is_alu | is_falu | is_ld | is_st | (is_sys & (xo <= `EPS_XO_MFSEG));
   // Segment moves are illegal when the bridge group is absent. [RQ18]
   wire unsup = ~known | (x_seg & (BRIDGE_SUPPORTED == 0)) | ((x_mtspr | x_mfspr) & ~sp_known);
   // Time base reads and system call stay open to user code; everything else here is supervisor-only. [RQ13] [RQ14]
   wire need_sup = x_rfi | x_mtmsr | x_mfmsr | x_mtspr | (x_mfspr & sp_impl) | x_seg;

   wire accept  = instr_valid & instr_ready;
   wire prog_f  = accept & unsup;
   wire priv_f  = accept & ~unsup & pr_ff & need_sup; // [RQ19]
   wire ok      = accept & ~unsup & ~priv_f;

   // Effective address: base register (zero for index 0) plus displacement.
   wire [63:0] base = (ra == 5'h00) ? 64'h0000_0000_0000_0000 : general_reg[ra];
   wire [63:0] disp = {{55{instr_word[10]}}, instr_word[`EPS_F_DISP]};
   wire [63:0] ea   = base + disp;
   wire [1:0]  acc_size = is_mult ? `EPS_SZ_WORD : (is_flt ? `EPS_SZ_DWORD : instr_word[`EPS_F_SZ]); // [RQ7]
   wire        chk_aligned;

   eps_align u_chk
   (
      .off     (ea[2:0]),
      .size    (acc_size),
      .aligned (chk_aligned),
      .be      ()
   );

   eps_align u_lane
   (
      .off     (ea_ff[2:0]),
      .size    (size_ff),
      .aligned (),
      .be      (mem_be)
   );

   wire is_mem  = is_ld | is_st;
   wire mis_f   = ok & is_mem & ~chk_aligned; // [RQ8]
   wire go_mem  = ok & is_mem & chk_aligned;

   // Order bits are reserved, held at zero, when little-endian is absent. [RQ4]
   wire eff_le  = (LE_SUPPORTED != 0) & le_ff;
   wire [63:0] src_rt = general_reg[rt];

   wire [31:0] tb_lo;
   wire [31:0] tb_hi;

   eps_timebase u_tb
   (
      .clk   (clk),
      .rst_n (rst_n),
      .wr_lo (ok & x_mtspr & sp_tbl), // [RQ13]
      .wr_hi (ok & x_mtspr & sp_tbu),
      .wdata (src_rt[31:0]),
      .tb_lo (tb_lo),
      .tb_hi (tb_hi)
   );

   assign machine_state_reg = ({63'h0, eff_le} << `EPS_MSR_LE)
                            | ({63'h0, pr_ff} << `EPS_MSR_PR)
                            | ({63'h0, ile_ff & (LE_SUPPORTED != 0)} << `EPS_MSR_ILE);
   assign user_mode   = pr_ff;
   assign instr_ready = (state_ff == S_IDLE) & ~exc_take;
   assign mem_req     = (state_ff == S_MEM); // [RQ9]
   assign mem_addr    = {ea_ff[63:3], 3'b000};

   wire last_beat = ~mult_ff | (tgt_ff == `EPS_LAST_REG);
   wire beat_done = mem_req & mem_ack;
   wire [4:0]  tgt_inc = tgt_ff + 5'h01;

   // Internal register-file write: load data or moves from state registers.
   reg         iw_en;
   reg         iw_flt;
   reg  [4:0]  iw_idx;
   reg  [63:0] iw_data;

   always @*
   begin
      iw_en   = 1'b0;
      iw_flt  = 1'b0;
      iw_idx  = rt;
      iw_data = 64'h0000_0000_0000_0000;
      if (beat_done & ~mem_we_ff)
      begin
         iw_en   = 1'b1;
         iw_flt  = flt_ff;
         iw_idx  = tgt_ff;
         iw_data = ld_extract(mem_rdata, ea_ff[2:0], size_ff, eff_le);
      end
      else if (ok & x_mfmsr)
      begin
         iw_en   = 1'b1;
         iw_data = machine_state_reg;
      end
      else if (ok & x_mfspr)
      begin
         iw_en   = 1'b1;
         iw_data = sp_impl ? impl_specific_reg_ff : {32'h0000_0000, sp_tbu ? tb_hi : tb_lo};
      end
   end

   // Register files; the internal write wins when both ports hit one index. [RQ10]
   always @(posedge clk)
   begin
      if (res_valid)
      begin
         if (res_float)
            float_reg[res_idx] <= res_single ? rnd_single(res_data) : res_data; // [RQ17] [RQ16]
         else
            general_reg[res_idx] <= res_data;
      end
      if (iw_en)
      begin
         if (iw_flt)
            float_reg[iw_idx] <= iw_data;
         else
            general_reg[iw_idx] <= iw_data;
      end
   end

   always @*
   begin
      case (state_ff)
         S_IDLE:  nxt_state = go_mem ? S_MEM : S_IDLE;
         S_MEM:   nxt_state = (mem_ack & last_beat) ? S_IDLE : S_MEM;
         default: nxt_state = S_IDLE;
      endcase
   end

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff             <= S_IDLE;
         pr_ff                <= `EPS_RST_PR;
         le_ff                <= `EPS_RST_LE; // [RQ1]
         ile_ff               <= `EPS_RST_ILE;
         save_pr_ff           <= `EPS_RST_PR;
         save_le_ff           <= `EPS_RST_LE;
         impl_specific_reg_ff <= 64'h0000_0000_0000_0000;
         ea_ff                <= 64'h0000_0000_0000_0000;
         size_ff              <= `EPS_SZ_BYTE;
         flt_ff               <= 1'b0;
         mult_ff              <= 1'b0;
         tgt_ff               <= 5'h00;
         mem_we_ff            <= 1'b0;
         mem_wdata_ff         <= 64'h0000_0000_0000_0000;
         instr_done_ff        <= 1'b0;
         exc_priv_ff          <= 1'b0;
         exc_prog_ff          <= 1'b0;
         exc_align_ff         <= 1'b0;
         seg_op_ff            <= 1'b0;
         ex_issue_ff          <= 1'b0;
         ex_float_ff          <= 1'b0;
         ex_single_ff         <= 1'b0;
         ex_target_ff         <= 5'h00;
         ex_opa_ff            <= 64'h0000_0000_0000_0000;
         ex_opb_ff            <= 64'h0000_0000_0000_0000;
      end
      else
      begin
         state_ff      <= nxt_state;
         exc_priv_ff   <= priv_f; // [RQ19]
         exc_prog_ff   <= prog_f; // [RQ18]
         exc_align_ff  <= mis_f;
         seg_op_ff     <= ok & x_seg;
         ex_issue_ff   <= ok & (is_alu | is_falu);
         instr_done_ff <= (ok & ~is_mem) | (beat_done & last_beat);

         // Exception entry and system call both enter supervisor level. [RQ3] [RQ15]
         if (exc_take | (ok & x_sc))
         begin
            save_pr_ff <= pr_ff;
            save_le_ff <= le_ff;
            pr_ff      <= 1'b0;
            le_ff      <= (LE_SUPPORTED != 0) & ile_ff; // [RQ3]
         end
         else if (ok & x_rfi)
         begin
            pr_ff <= save_pr_ff; // [RQ15]
            le_ff <= save_le_ff;
         end
         else if (ok & x_mtmsr)
         begin
            pr_ff  <= src_rt[`EPS_MSR_PR]; // [RQ14]
            le_ff  <= (LE_SUPPORTED != 0) & src_rt[`EPS_MSR_LE]; // [RQ4]
            ile_ff <= (LE_SUPPORTED != 0) & src_rt[`EPS_MSR_ILE];
         end

         if (ok & x_mtspr & sp_impl)
            impl_specific_reg_ff <= src_rt; // [RQ14]

         // Operands come from registers or the immediate field only. [RQ9] [RQ12]
         if (ok & (is_alu | is_falu))
         begin
            ex_float_ff  <= is_falu;
            ex_single_ff <= is_falu & sel;
            ex_target_ff <= rt; // [RQ10]
            ex_opa_ff    <= is_falu ? float_reg[ra] : general_reg[ra];
            if (is_falu)
               ex_opb_ff <= float_reg[rb];
            else if (sel)
               ex_opb_ff <= {{49{instr_word[15]}}, instr_word[`EPS_F_IMM]};
            else
               ex_opb_ff <= general_reg[rb];
         end

         if (go_mem)
         begin
            ea_ff        <= ea; // [RQ6]
            size_ff      <= acc_size;
            flt_ff       <= is_flt;
            mult_ff      <= is_mult;
            tgt_ff       <= rt;
            mem_we_ff    <= is_st;
            mem_wdata_ff <= st_place(is_flt ? float_reg[rt] : src_rt, ea[2:0], acc_size, eff_le);
         end
         else if (beat_done & ~last_beat)
         begin
            // Word sequences step one register and one word per beat. [RQ7]
            ea_ff        <= ea_ff + `EPS_WORD_STEP;
            tgt_ff       <= tgt_inc;
            mem_wdata_ff <= st_place(general_reg[tgt_inc], ea_ff[2:0] ^ 3'h4, `EPS_SZ_WORD, eff_le);
         end
      end
   end

endmodule
`default_nettype wire

// *** eps_defs.vh ***
// Purpose: Shared constants of the processor-state block.
// Assumes: Included by every design file of the block by its bare name.
// Notes:   Opcodes, sub-ops and bit positions form the block's own decode map.
`ifndef EPS_DEFS_VH
`define EPS_DEFS_VH

// Instruction word fields.
`define EPS_F_OP     31:26
`define EPS_F_RT     25:21
`define EPS_F_RA     20:16
`define EPS_F_RB     15:11
`define EPS_F_IMM    15:1
`define EPS_F_DISP   10:2
`define EPS_F_XO     4:1
`define EPS_F_SZ     1:0
`define EPS_B_SEL    0

// Primary opcodes.
`define EPS_OP_ALU   6'h1F
`define EPS_OP_FALU  6'h3F
`define EPS_OP_LD    6'h20
`define EPS_OP_ST    6'h24
`define EPS_OP_LDF   6'h30
`define EPS_OP_STF   6'h34
`define EPS_OP_LMW   6'h2E
`define EPS_OP_STMW  6'h2F
`define EPS_OP_SYS   6'h13

// System sub-operations.
`define EPS_XO_SC    4'h0
`define EPS_XO_RFI   4'h1
`define EPS_XO_MTMSR 4'h2
`define EPS_XO_MFMSR 4'h3
`define EPS_XO_MTSPR 4'h4
`define EPS_XO_MFSPR 4'h5
`define EPS_XO_MTSEG 4'h6
`define EPS_XO_MFSEG 4'h7

// Special register numbers.
`define EPS_SPR_TBL  5'h0C
`define EPS_SPR_TBU  5'h0D
`define EPS_SPR_IMPL 5'h10

// Operand size codes.
`define EPS_SZ_BYTE  2'h0
`define EPS_SZ_HALF  2'h1
`define EPS_SZ_WORD  2'h2
`define EPS_SZ_DWORD 2'h3

// Machine state bit positions and reset values.
`define EPS_MSR_LE   0
`define EPS_MSR_PR   14
`define EPS_MSR_ILE  16
`define EPS_RST_LE   1'b0
`define EPS_RST_ILE  1'b0
`define EPS_RST_PR   1'b0

// Sequencing constants.
`define EPS_LAST_REG  5'h1F
`define EPS_WORD_STEP 64'h0000_0000_0000_0004

`endif

// *** eps_align.v ***
// Purpose: Alignment check and byte-lane enables of one memory operand.
// Assumes: Lane of byte offset k is data bits 63-8k down to 56-8k.
// Notes:   Pure combinational logic.
`timescale 1ns/1ps
`default_nettype none
`include "eps_defs.vh"
module eps_align
(
   // Operand.
   input  wire [2:0] off,
   input  wire [1:0] size,
   // Result.
   output reg        aligned,
   output reg  [7:0] be
);

   reg [7:0] top;

   always @*
   begin
      // Aligned only on a multiple of the operand length. [RQ8]
      case (size)
         `EPS_SZ_BYTE:
         begin
            top     = 8'h80;
            aligned = 1'b1;
         end
         `EPS_SZ_HALF:
         begin
            top     = 8'hC0;
            aligned = (off[0] == 1'b0);
         end
         `EPS_SZ_WORD:
         begin
            top     = 8'hF0;
            aligned = (off[1:0] == 2'h0);
         end
         default:
         begin
            top     = 8'hFF;
            aligned = (off == 3'h0);
         end
      endcase
      // The operand starts at its lowest-numbered byte. [RQ6] [RQ5]
      be = top >> off;
   end

endmodule
`default_nettype wire

// *** eps_timebase.v ***
// Purpose: Free-running 64-bit time base held as two 32-bit halves.
// Assumes: Write strobes are already gated by privilege.
// Notes:   A write to one half replaces it for that cycle's count.
`timescale 1ns/1ps
`default_nettype none
`include "eps_defs.vh"
module eps_timebase
(
   // Clock and reset.
   input  wire        clk,
   input  wire        rst_n,
   // Writes.
   input  wire        wr_lo,
   input  wire        wr_hi,
   input  wire [31:0] wdata,
   // Value.
   output wire [31:0] tb_lo,
   output wire [31:0] tb_hi
);

   reg  [63:0] count_ff;
   wire [63:0] inc = count_ff + 64'h0000_0000_0000_0001;

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         count_ff <= 64'h0000_0000_0000_0000;
      else
         count_ff <= {wr_hi ? wdata : inc[63:32], wr_lo ? wdata : inc[31:0]}; // [RQ13]
   end

   assign tb_lo = count_ff[31:0];
   assign tb_hi = count_ff[63:32];

endmodule
`default_nettype wire

// *** eps_core_chk.sv ***
// Purpose: Assertions on the core's ports.
// Assumes: One clock; reset async, active low.
// Notes:   Bound into every core instance.
`timescale 1ns/1ps
`default_nettype none
`include "eps_defs.vh"
module eps_core_chk
#(
   parameter LE_SUPPORTED     = 1,
   parameter BRIDGE_SUPPORTED = 0
)
(
   // Clock and reset.
   input wire logic        clk,
   input wire logic        rst_n,
   // Instruction stream.
   input wire logic        instr_valid,
   input wire logic [31:0] instr_word,
   input wire logic        instr_ready,
   input wire logic        instr_done_ff,
   input wire logic        exc_take,
   input wire logic        ex_issue_ff,
   input wire logic [4:0]  ex_target_ff,
   // Memory.
   input wire logic        mem_req,
   input wire logic        mem_we_ff,
   input wire logic [63:0] mem_addr,
   input wire logic [7:0]  mem_be,
   input wire logic        mem_ack,
   // Status.
   input wire logic [63:0] machine_state_reg,
   input wire logic        user_mode,
   input wire logic        exc_priv_ff,
   input wire logic        exc_prog_ff,
   input wire logic        exc_align_ff
);
   wire logic       take    = instr_valid && instr_ready;
   wire logic       acc_sys = take && (instr_word[`EPS_F_OP] == `EPS_OP_SYS);
   wire logic [3:0] xo      = instr_word[`EPS_F_XO];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   one_answer_a: assert property ($onehot0({instr_done_ff, exc_priv_ff, exc_prog_ff, exc_align_ff}))
      else $error("Two answers in one cycle.");
   fault_keeps_state_a: assert property ((exc_priv_ff || exc_prog_ff) |-> $stable(machine_state_reg))
      else $error("Fault changed machine state.");
   mode_bit_tie_a: assert property (user_mode == machine_state_reg[`EPS_MSR_PR])
      else $error("User mode output mismatch.");
   entry_order_a: assert property ((exc_take || (acc_sys && xo == `EPS_XO_SC)) |=> !user_mode &&
      machine_state_reg[`EPS_MSR_LE] == ((LE_SUPPORTED != 0) && $past(machine_state_reg[`EPS_MSR_ILE])))
      else $error("Bad state after entry.");
   busy_refuses_a: assert property ((exc_take || mem_req) |-> !instr_ready)
      else $error("Ready while busy.");
   beat_holds_a: assert property (mem_req && !mem_ack |=>
      mem_req && $stable(mem_addr) && $stable(mem_be) && $stable(mem_we_ff))
      else $error("Beat changed before ack.");
   beat_lanes_a: assert property (mem_req |-> mem_addr[2:0] == 3'h0 && mem_be != 8'h00)
      else $error("Bad beat address or lanes.");
   alu_issue_a: assert property (take && instr_word[`EPS_F_OP] == `EPS_OP_ALU |=>
      ex_issue_ff && instr_done_ff && ex_target_ff == $past(instr_word[`EPS_F_RT]))
      else $error("ALU op not issued.");
   user_priv_a: assert property (acc_sys && user_mode &&
      (xo == `EPS_XO_RFI || xo == `EPS_XO_MTMSR || (xo == `EPS_XO_MTSPR && instr_word[15:12] == 4'h6)) |=> exc_priv_ff)
      else $error("User privileged op not refused.");
   seg_prog_a: assert property (acc_sys && BRIDGE_SUPPORTED == 0 &&
      (xo == `EPS_XO_MTSEG || xo == `EPS_XO_MFSEG) |=> exc_prog_ff)
      else $error("Segment move not refused.");
   align_no_beat_a: assert property (exc_align_ff |-> !mem_req ##1 !mem_req)
      else $error("Misaligned beat.");
   last_beat_done_a: assert property (mem_req && mem_ack ##1 !mem_req |-> instr_done_ff)
      else $error("Memory op not completed.");
   cover property (exc_take);
   cover property (mem_req && mem_ack && mem_we_ff);
   cover property (exc_priv_ff);
   cover property (exc_align_ff);
endmodule
bind eps_core eps_core_chk #(.LE_SUPPORTED(LE_SUPPORTED), .BRIDGE_SUPPORTED(BRIDGE_SUPPORTED)) i_chk (.*);
`default_nettype wire

// *** eps_core_test.sv ***
// Purpose: Bench of the processor-state core.
// Assumes: Little-endian support on, segment moves not supported.
// Notes:   Memory beats are acked after two waits.
`timescale 1ns/1ps
`default_nettype none
`include "eps_defs.vh"
module eps_core_test;
   logic        clk, rst_n, instr_valid, exc_take, res_valid, res_float, res_single, mem_ack;
   logic [31:0] instr_word;
   logic [4:0]  res_idx;
   logic [63:0] res_data, mem_rdata;
   wire         instr_ready, instr_done_ff, ex_issue_ff, ex_float_ff, ex_single_ff, mem_req, mem_we_ff;
   wire         user_mode, exc_priv_ff, exc_prog_ff, exc_align_ff, seg_op_ff;
   wire  [4:0]  ex_target_ff;
   wire  [7:0]  mem_be;
   wire  [63:0] ex_opa_ff, ex_opb_ff, mem_addr, mem_wdata_ff, machine_state_reg;
   int          error_cnt = 0;
   int          comparisons = 0;
   // Rows: size, offset, aligned, lanes.
   logic [13:0] rows [7] = '{{2'h0, 3'h3, 1'b1, 8'h10}, {2'h1, 3'h2, 1'b1, 8'h30}, {2'h1, 3'h1, 1'b0, 8'h00},
      {2'h2, 3'h4, 1'b1, 8'h0F}, {2'h2, 3'h2, 1'b0, 8'h00}, {2'h3, 3'h0, 1'b1, 8'hFF}, {2'h3, 3'h4, 1'b0, 8'h00}};
   logic [3:0]  fx [4] = '{`EPS_XO_MTMSR, `EPS_XO_MTSPR, `EPS_XO_RFI, `EPS_XO_MTSEG};
   eps_core #(.LE_SUPPORTED(1), .BRIDGE_SUPPORTED(0)) i_dut (.*);
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic summarize(input int lost = 0);
      error_cnt += lost;
      if (error_cnt == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input logic [63:0] got, exp);
      comparisons++;
      if (got !== exp)
      begin
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
         error_cnt++;
      end
   endtask
   function automatic logic [31:0] mk(input logic [5:0] op, input logic [4:0] rt, ra, rb, input logic [10:0] low);
      return {op, rt, ra, rb, low};
   endfunction
   function automatic logic [10:0] sys(input logic [3:0] xo);
      return {6'h00, xo, 1'b0};
   endfunction
   task automatic wreg(input logic f, input logic [4:0] idx, input logic [63:0] d, input logic s);
      @(negedge clk);
      res_valid  = 1'b1;
      res_float  = f;
      res_single = s;
      res_idx    = idx;
      res_data   = d;
      @(negedge clk);
      res_valid = 1'b0;
   endtask
   // Offers one instruction and returns in the cycle after it was taken.
   task automatic issue(input logic [31:0] w);
      int n;
      @(negedge clk);
      instr_valid = 1'b1;
      instr_word  = w;
      for (n = 0; n < 20 && instr_ready !== 1'b1; n++)
         @(negedge clk);
      if (n == 20)
         summarize(1);
      @(negedge clk);
      instr_valid = 1'b0;
   endtask
   task automatic outs(input logic [3:0] exp);
      check(64'({seg_op_ff, instr_done_ff, exc_priv_ff, exc_prog_ff, exc_align_ff}), 64'(exp));
   endtask
   task automatic rd(input logic f, input logic [4:0] idx, input logic [63:0] exp);
      issue(mk(f ? `EPS_OP_FALU : `EPS_OP_ALU, 5'h01, idx, idx, 11'h000));
      check(64'({ex_issue_ff, ex_float_ff, ex_single_ff, instr_done_ff}), 64'({1'b1, f, 1'b0, 1'b1}));
      check(ex_opa_ff, exp);
   endtask
   task automatic beat(input logic [63:0] a, input logic [7:0] be, input logic we,
                       input logic [63:0] rdat, wm, wd, input logic last);
      int n;
      for (n = 0; n < 8 && mem_req !== 1'b1; n++)
         @(negedge clk);
      if (n == 8)
         summarize(1);
      check(mem_addr, a);
      check(64'({mem_we_ff, mem_be}), 64'({we, be}));
      check(mem_wdata_ff & wm, wd);
      repeat (2) @(negedge clk);
      mem_ack   = 1'b1;
      mem_rdata = rdat;
      @(negedge clk);
      mem_ack   = 1'b0;
      mem_rdata = ~rdat;
      if (last)
         check(64'({mem_req, instr_done_ff}), 64'h1);
   endtask
   initial
   begin
      logic [1:0]  sz;
      logic [2:0]  off;
      logic        al;
      logic [7:0]  be;
      logic [63:0] base, pat;
      {instr_valid, exc_take, res_valid, res_float, res_single, mem_ack} = 6'h00;
      {instr_word, res_idx, res_data, mem_rdata} = '0;
      base = 64'h0000_0000_0000_1000;
      pat  = 64'h1122_3344_5566_7788;
      rst_n = 1'b0;
      repeat (10) @(negedge clk);
      check(machine_state_reg, 64'h0000);
      check(64'({instr_ready, mem_req, user_mode}), 64'h0004);
      rst_n = 1'b1;
      for (int i = 0; i < 7; i++)
      begin
         {sz, off, al, be} = rows[i];
         wreg(1'b0, 5'h05, base + 64'(off), 1'b0);
         issue(mk(`EPS_OP_LD, 5'h05, 5'h05, 5'h00, {9'h000, sz}));
         if (al)
         begin
            beat(base, be, 1'b0, pat, 64'h0000, 64'h0000, 1'b1);
            rd(1'b0, 5'h05, (pat << (8 * off)) >> (64 - 8 * (1 << sz)));
         end
         else
         begin
            outs(4'h1);
            check(64'(mem_req), 64'h0000);
         end
      end
      wreg(1'b0, 5'h1E, 64'hAAAA_BBBB_0102_0304, 1'b0);
      wreg(1'b0, 5'h1F, 64'hCCCC_DDDD_0506_0708, 1'b0);
      wreg(1'b0, 5'h05, base, 1'b0);
      issue(mk(`EPS_OP_STMW, 5'h1E, 5'h05, 5'h00, 11'h000));
      beat(base, 8'hF0, 1'b1, pat, 64'hFFFF_FFFF_0000_0000, 64'h0102_0304_0000_0000, 1'b0);
      beat(base, 8'h0F, 1'b1, pat, 64'h0000_0000_FFFF_FFFF, 64'h0000_0000_0506_0708, 1'b1);
      wreg(1'b1, 5'h03, 64'h3FF0_0000_1000_0001, 1'b1);
      rd(1'b1, 5'h03, 64'h3FF0_0000_2000_0000);
      wreg(1'b1, 5'h04, 64'h3FF0_0000_1000_0001, 1'b0);
      rd(1'b1, 5'h04, 64'h3FF0_0000_1000_0001);
      issue(mk(`EPS_OP_ALU, 5'h07, 5'h05, 5'h10, 11'h001));
      check(64'({ex_target_ff, instr_done_ff}), 64'h000F);
      check(ex_opb_ff, 64'hFFFF_FFFF_FFFF_C000);
      wreg(1'b0, 5'h09, 64'h0000_0000_1234_5678, 1'b0);
      wreg(1'b0, 5'h0A, 64'h0000_0000_0001_0000, 1'b0);
      wreg(1'b0, 5'h0B, 64'h0000_0000_0001_4000, 1'b0);
      issue(mk(`EPS_OP_SYS, 5'h09, 5'h09, `EPS_SPR_TBU, sys(`EPS_XO_MTSPR)));
      outs(4'h8);
      issue(mk(`EPS_OP_SYS, 5'h0A, 5'h0A, 5'h0A, sys(`EPS_XO_MTMSR)));
      check(machine_state_reg, 64'h0000_0000_0001_0000);
      @(negedge clk);
      exc_take = 1'b1;
      #1 check(64'(instr_ready), 64'h0000);
      @(negedge clk);
      exc_take = 1'b0;
      check(machine_state_reg, 64'h0000_0000_0001_0001);
      issue(mk(`EPS_OP_SYS, 5'h0B, 5'h0B, 5'h0B, sys(`EPS_XO_MTMSR)));
      check(64'({user_mode, machine_state_reg[31:0]}), 64'h0001_0001_4000);
      for (int i = 0; i < 4; i++)
      begin
         issue(mk(`EPS_OP_SYS, 5'h0A, 5'h0A, `EPS_SPR_TBU, sys(fx[i])));
         outs(i == 3 ? 4'h2 : 4'h4);
         check(machine_state_reg, 64'h0000_0000_0001_4000);
      end
      issue(mk(`EPS_OP_SYS, 5'h0C, 5'h0C, `EPS_SPR_TBU, sys(`EPS_XO_MFSPR)));
      outs(4'h8);
      rd(1'b0, 5'h0C, 64'h0000_0000_1234_5678);
      issue(mk(`EPS_OP_SYS, 5'h00, 5'h00, 5'h00, sys(`EPS_XO_SC)));
      check(machine_state_reg, 64'h0000_0000_0001_0001);
      issue(mk(`EPS_OP_SYS, 5'h00, 5'h00, 5'h00, sys(`EPS_XO_RFI)));
      check(machine_state_reg, 64'h0000_0000_0001_4000);
      summarize();
   end
endmodule
`default_nettype wire
